// file: verilog/sar_ctrl_pkg.sv
// constants, types and register map of the converter serial control block
package sar_ctrl_pkg;

  // analog input range selection
  typedef enum logic [1:0] {
    RANGE_FULL_DIFF,
    RANGE_UNIPOLAR,
    RANGE_BIPOLAR,
    RANGE_SPARE
  } range_t;

  // one sequencer configuration word, msb first on the serial line
  typedef struct packed {
    logic       spare;
    logic [2:0] channel;
    range_t     in_range;
    logic       twos;
    logic       gain_compression;
  } cfg_t;

  // sticky event bits, shared by status and mask registers
  typedef struct packed {
    logic cfg_loaded;
    logic conv_aborted;
    logic conv_done;
  } irq_t;

  localparam int CODE_W   = 16;
  localparam int CFG_W    = $bits(cfg_t);
  localparam int TX_W     = CODE_W + CFG_W;
  localparam int IRQ_W    = $bits(irq_t);
  localparam int NPIN     = 5;

  // synchronised pin positions
  localparam int PIN_CONV = 0;
  localparam int PIN_RDL  = 1;
  localparam int PIN_SCK  = 2;
  localparam int PIN_SDI  = 3;
  localparam int PIN_RST  = 4;

  // pin levels while idle; the synchronisers start here so reset shows no false bus enable
  localparam logic [NPIN-1:0] PIN_IDLE = 5'h02;

  // conversion timing from the internal oscillator
  localparam int CLK_PERIOD_PS = 25000;
  localparam int CONV_TIME_NS  = 360;
  localparam int CONV_CYCLES   = (CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // apb register byte offsets
  localparam logic [7:0] OFS_CONFIG     = 8'h00;
  localparam logic [7:0] OFS_STATUS     = 8'h04;
  localparam logic [7:0] OFS_RESULT     = 8'h08;
  localparam logic [7:0] OFS_INT_STATUS = 8'h0C;
  localparam logic [7:0] OFS_INT_MASK   = 8'h10;

  // status register bit positions
  localparam int STAT_BUSY   = 0;
  localparam int STAT_BUS_EN = 1;

  // values after reset
  localparam logic [7:0]  CFG_RESET  = 8'h00;
  localparam logic [15:0] CODE_RESET = 16'h0000;
  localparam logic [2:0]  IRQ_RESET  = 3'h0;
  localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;

endpackage

// file: verilog/sar_adc_serial_control.sv
// converter control, serial data port and apb register slave
`timescale 1ns/1ps
module sar_adc_serial_control (
  input  wire logic                          sys_clk,
  input  wire logic                          reset_n,
  // apb slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // device pins
  input  wire logic                          convert_start,
  input  wire logic                          read_enable_n,
  input  wire logic                          sck,
  input  wire logic                          sdi,
  input  wire logic                          dev_reset,
  output logic                               busy,
  output logic                               sdo,
  output logic                               sdo_oe_n,
  // analog core side
  input  wire logic [sar_ctrl_pkg::CODE_W-1:0] core_code,
  output logic                               core_wake,
  output logic [2:0]                         mux_channel,
  output sar_ctrl_pkg::range_t               input_range,
  output logic                               gain_compression,
  output logic                               irq
);
  import sar_ctrl_pkg::*;

  typedef enum logic {ST_NAP, ST_CONVERT} conv_state_t;

  conv_state_t       state_r;
  logic [NPIN-1:0]   pin_meta_r;
  logic [NPIN-1:0]   pin_sync_r;
  logic              conv_prev_r;
  logic              sck_prev_r;
  logic [4:0]        conv_cnt_r;
  logic              busy_r;
  logic [CODE_W-1:0] result_r;
  logic [TX_W-1:0]   tx_shift_r;
  logic [CFG_W-1:0]  rx_shift_r;
  logic [2:0]        rx_cnt_r;
  cfg_t              cfg_r;
  irq_t              int_stat_r;
  irq_t              int_mask_r;
  logic              oe_n_r;
  logic [31:0]       prdata_r;
  logic              pslverr_r;

  logic              dev_rst;
  logic              bus_en;
  logic              conv_rise;
  logic              sck_rise;
  logic              conv_go;
  logic              conv_end;
  logic              abort;
  logic              capture;
  logic              cfg_load;
  logic [CFG_W-1:0]  rx_word;
  logic              apb_wr;
  logic              apb_rd;
  irq_t              evt;
  irq_t              w1c;

  // offset binary to output coding; msb flip gives twos complement
  function automatic logic [CODE_W-1:0] out_code(input logic [CODE_W-1:0] raw,
                                                 input cfg_t c);
    logic flip;
    flip = c.twos && (c.in_range != RANGE_UNIPOLAR);
    out_code = {raw[CODE_W-1] ^ flip, raw[CODE_W-2:0]};
  endfunction

  // true when the address names a mapped register
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == OFS_CONFIG) || (a == OFS_STATUS) || (a == OFS_RESULT) ||
                (a == OFS_INT_STATUS) || (a == OFS_INT_MASK);
  endfunction

  // two flip-flops on every pin; nothing reads pin_meta_r but pin_sync_r
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pin_meta_r <= PIN_IDLE;
      pin_sync_r <= PIN_IDLE;
    end else begin
      pin_meta_r <= {dev_reset, sdi, sck, read_enable_n, convert_start};
      pin_sync_r <= pin_meta_r;
    end
  end

  // edge detectors work on the synchronised copies only
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      conv_prev_r <= 1'b0;
      sck_prev_r  <= 1'b0;
    end else begin
      conv_prev_r <= pin_sync_r[PIN_CONV];
      sck_prev_r  <= pin_sync_r[PIN_SCK];
    end
  end

  assign dev_rst   = pin_sync_r[PIN_RST];
  assign bus_en    = !pin_sync_r[PIN_RDL] && !dev_rst;
  assign conv_rise = pin_sync_r[PIN_CONV] && !conv_prev_r;
  // shift clock is gated by read enable, so edges while disabled are dropped
  assign sck_rise  = pin_sync_r[PIN_SCK] && !sck_prev_r && bus_en;
  // a convert edge during a conversion is ignored, not queued
  assign conv_go   = conv_rise && (state_r == ST_NAP) && !dev_rst;
  assign conv_end  = (state_r == ST_CONVERT) && !dev_rst &&
                     (conv_cnt_r == 5'(CONV_CYCLES - 1));
  assign abort     = dev_rst && (state_r == ST_CONVERT);
  assign capture   = sck_rise;
  assign rx_word   = {rx_shift_r[CFG_W-2:0], pin_sync_r[PIN_SDI]};
  assign cfg_load  = capture && (rx_cnt_r == 3'(CFG_W - 1));

  // conversion sequencer: nap until a convert edge, then count the oscillator time
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_r    <= ST_NAP;
      conv_cnt_r <= '0;
    end else if (dev_rst) begin
      state_r    <= ST_NAP;
      conv_cnt_r <= '0;
    end else begin
      unique case (state_r)
        ST_NAP: begin
          conv_cnt_r <= '0;
          if (conv_go) begin
            state_r <= ST_CONVERT;
          end
        end
        ST_CONVERT: begin
          conv_cnt_r <= conv_cnt_r + 5'd1;
          if (conv_end) begin
            state_r <= ST_NAP;
          end
        end
      endcase
    end
  end

  // busy rises with the start edge and falls when the result is ready
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      busy_r <= 1'b0;
    end else if (dev_rst || conv_end) begin
      busy_r <= 1'b0;
    end else if (conv_go) begin
      busy_r <= 1'b1;
    end
  end

  // result latch, coded with the configuration active in the cycle the conversion ends
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      result_r <= CODE_RESET;
    end else if (conv_end) begin
      result_r <= out_code(core_code, cfg_r);
    end
  end

  // output shifter: result msb first, then the active configuration word
  always_ff @(posedge sys_clk) begin
    if (!reset_n || dev_rst) begin
      tx_shift_r <= '0;
    end else if (conv_end) begin
      tx_shift_r <= {out_code(core_code, cfg_r), cfg_r};
    end else if (sck_rise) begin
      tx_shift_r <= {tx_shift_r[TX_W-2:0], 1'b0};
    end
  end

  // input shifter; the bit count restarts whenever the bus is released
  always_ff @(posedge sys_clk) begin
    if (!reset_n || !bus_en) begin
      rx_shift_r <= '0;
      rx_cnt_r   <= '0;
    end else if (capture) begin
      rx_shift_r <= rx_word;
      rx_cnt_r   <= rx_cnt_r + 3'd1;
    end
  end

  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && penable && !pwrite;

  // active configuration; a serial word wins over a same-cycle apb write
  always_ff @(posedge sys_clk) begin
    if (!reset_n || dev_rst) begin
      cfg_r <= cfg_t'(CFG_RESET);
    end else if (cfg_load) begin
      cfg_r <= cfg_t'(rx_word);
    end else if (apb_wr && paddr == OFS_CONFIG) begin
      cfg_r <= cfg_t'(pwdata[CFG_W-1:0]);
    end
  end

  // bus driver enable registered so it cannot glitch on pin noise
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      oe_n_r <= 1'b1;
    end else begin
      oe_n_r <= !bus_en;
    end
  end

  // sticky events; a set in the clearing cycle survives the clear
  assign evt.conv_done    = conv_end;
  assign evt.conv_aborted = abort;
  assign evt.cfg_loaded   = cfg_load;
  assign w1c = (apb_wr && paddr == OFS_INT_STATUS) ? irq_t'(pwdata[IRQ_W-1:0])
                                                   : irq_t'(IRQ_RESET);

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      int_stat_r <= irq_t'(IRQ_RESET);
    end else begin
      int_stat_r <= (int_stat_r & ~w1c) | evt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      int_mask_r <= irq_t'(IRQ_RESET);
    end else if (apb_wr && paddr == OFS_INT_MASK) begin
      int_mask_r <= irq_t'(pwdata[IRQ_W-1:0]);
    end
  end

  // read data and error flag registered in the setup cycle, ready in the access cycle
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      prdata_r  <= WORD_ZERO;
      pslverr_r <= 1'b0;
    end else if (psel && !penable) begin
      pslverr_r <= !is_mapped(paddr);
      prdata_r  <= WORD_ZERO;
      if (!pwrite) begin
        unique case (paddr)
          OFS_CONFIG:     prdata_r <= {24'h00_0000, cfg_r};
          OFS_STATUS:     prdata_r <= {30'h0000_0000, bus_en, busy_r};
          OFS_RESULT:     prdata_r <= {16'h0000, result_r};
          OFS_INT_STATUS: prdata_r <= {29'h0000_0000, int_stat_r};
          OFS_INT_MASK:   prdata_r <= {29'h0000_0000, int_mask_r};
          default:        prdata_r <= WORD_ZERO;
        endcase
      end
    end
  end

  assign prdata           = apb_rd ? prdata_r : WORD_ZERO;
  assign pready           = 1'b1;
  assign pslverr          = psel && penable && pslverr_r;
  assign busy             = busy_r;
  assign sdo              = tx_shift_r[TX_W-1];
  assign sdo_oe_n         = oe_n_r;
  assign core_wake        = busy_r;
  assign mux_channel      = cfg_r.channel;
  assign input_range      = cfg_r.in_range;
  assign gain_compression = cfg_r.gain_compression;
  assign irq              = |(int_stat_r & int_mask_r);

  // ---------------- assertions ----------------
  localparam int CONV_WAIT = CONV_CYCLES;

  // cycles busy has stood high; a counter keeps the length checks free of long repeats
  logic [4:0] busy_len_r;

  always_ff @(posedge sys_clk) begin
    if (!reset_n || !busy_r) begin
      busy_len_r <= '0;
    end else begin
      busy_len_r <= busy_len_r + 5'd1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence s_start;
    conv_go;
  endsequence

  sequence s_busy_run;
    busy_r [*2];
  endsequence

  property p_start_busy;
    s_start |=> s_busy_run;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("busy did not follow convert edge");

  property p_busy_len;
    $fell(busy_r) && !$past(dev_rst) |-> busy_len_r == 5'(CONV_WAIT);
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");

  property p_busy_max;
    busy_r |-> busy_len_r < 5'(CONV_WAIT);
  endproperty
  a_busy_max: assert property (p_busy_max) else $error("busy high too long");

  property p_busy_hold;
    busy_r && !dev_rst && !conv_end |=> busy_r;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy fell early");

  property p_hiz;
    pin_sync_r[PIN_RDL] |=> sdo_oe_n;
  endproperty
  a_hiz: assert property (p_hiz) else $error("sdo driven while disabled");

  property p_gate;
    pin_sync_r[PIN_RDL] && !conv_end && !dev_rst |=> $stable(tx_shift_r) && rx_cnt_r == 3'd0;
  endproperty
  a_gate: assert property (p_gate) else $error("shift while disabled");

  property p_capture;
    capture && !cfg_load |=> rx_shift_r[0] == $past(pin_sync_r[PIN_SDI]);
  endproperty
  a_capture: assert property (p_capture) else $error("sdi bit not captured");

  property p_cfg;
    cfg_load && !dev_rst |=> cfg_r == $past(rx_word);
  endproperty
  a_cfg: assert property (p_cfg) else $error("config word not loaded");

  property p_shift;
    sck_rise && !conv_end && !dev_rst |=>
      tx_shift_r == {$past(tx_shift_r[TX_W-2:0]), 1'b0};
  endproperty
  a_shift: assert property (p_shift) else $error("output shift wrong");

  property p_coding;
    conv_end |=> result_r[CODE_W-2:0] == $past(core_code[CODE_W-2:0]) &&
      result_r[CODE_W-1] == ($past(core_code[CODE_W-1]) ^
        ($past(cfg_r.twos) && $past(cfg_r.in_range) != RANGE_UNIPOLAR));
  endproperty
  a_coding: assert property (p_coding) else $error("output coding wrong");

  property p_unipolar;
    conv_end && cfg_r.in_range == RANGE_UNIPOLAR |=> result_r == $past(core_code);
  endproperty
  a_unipolar: assert property (p_unipolar) else $error("unipolar code not straight binary");

  property p_reset;
    dev_rst |=> !busy_r && sdo_oe_n && state_r == ST_NAP;
  endproperty
  a_reset: assert property (p_reset) else $error("reset did not abort");

endmodule // sar_adc_serial_control

// file: tb/host_model.sv
// host side model: convert pin, serial bus master and result capture
`timescale 1ns/1ps
module host_model (
  input  wire logic sys_clk,
  output logic      convert_start,
  output logic      read_enable_n,
  output logic      sck,
  output logic      sdi,
  input  wire logic sdo,
  input  wire logic sdo_oe_n
);
  import sar_ctrl_pkg::*;
  localparam int HALF = 4; // 100 ns half period, a 200 ns shift clock
  // a released output floats, so a late sample shows z and never matches
  wire sdo_line = sdo_oe_n ? 1'bz : sdo;

  // pins idle: bus disabled, shift clock parked low
  initial begin
    convert_start = 1'b0;
    read_enable_n = 1'b1;
    sck           = 1'b0;
    sdi           = 1'b0;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // pulse longer than the pin's minimum high time
  task automatic convert();
    @(posedge sys_clk);
    convert_start <= 1'b1;
    cyc(2);
    convert_start <= 1'b0;
  endtask

  // n rising edges, config word repeated msb first, sdo sampled before each rise
  task automatic shift(input int n, input cfg_t w, output logic [TX_W-1:0] got);
    got = '0;
    for (int i = 0; i < n; i++) begin
      sdi <= w[CFG_W-1-(i%CFG_W)];
      cyc(HALF);
      got = {got[TX_W-2:0], sdo_line};
      sck <= 1'b1;
      cyc(HALF);
      sck <= 1'b0;
    end
    sdi <= ~sdi; // idle data line shows the inverse of the last bit
  endtask

  // full frame; the task does not wait on busy, the bench calls it once busy has fallen
  task automatic xfer(input cfg_t w, output logic [TX_W-1:0] got);
    @(posedge sys_clk);
    read_enable_n <= 1'b0;
    cyc(2*HALF);
    shift(TX_W, w, got);
    cyc(HALF);
    read_enable_n <= 1'b1;
    cyc(2*HALF);
  endtask
endmodule // host_model

// file: tb/test_sar_adc_serial_control.sv
// self-checking bench for the converter serial control block
`timescale 1ns/1ps
module test_sar_adc_serial_control;
  import sar_ctrl_pkg::*;
  localparam logic [7:0] OFS_LIST [5] = '{OFS_CONFIG, OFS_STATUS, OFS_RESULT,
                                          OFS_INT_STATUS, OFS_INT_MASK};
  logic            sys_clk, reset_n, psel, penable, pwrite, dev_reset, err;
  logic            pready, pslverr, busy, sdo, sdo_oe_n, core_wake, irq;
  logic            convert_start, read_enable_n, sck, sdi, gain_compression;
  logic [7:0]      paddr;
  logic [31:0]     pwdata, prdata, rd;
  logic [15:0]     core_code, code;
  logic [2:0]      mux_channel;
  range_t          input_range;
  cfg_t            cfg, ncfg;
  logic [TX_W-1:0] frame;
  int              n_errors, checked, seed, n;

  sar_adc_serial_control dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .convert_start(convert_start),
    .read_enable_n(read_enable_n), .sck(sck), .sdi(sdi), .dev_reset(dev_reset),
    .busy(busy), .sdo(sdo), .sdo_oe_n(sdo_oe_n), .core_code(core_code),
    .core_wake(core_wake), .mux_channel(mux_channel), .input_range(input_range),
    .gain_compression(gain_compression), .irq(irq));
  host_model hm (
    .sys_clk(sys_clk), .convert_start(convert_start), .read_enable_n(read_enable_n),
    .sck(sck), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n));

  // 40 MHz system clock
  initial sys_clk = 1'b0;
  always #12.5 sys_clk = ~sys_clk;

  task automatic end_of_test();
    $display("counts: %0d checked, %0d errors", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic fail();
    $display("ERROR wait timed out");
    n_errors++;
    end_of_test();
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer; data taken at the edge that samples pready high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    if (k == 16) fail();
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // counts edges until busy shows the wanted level
  task automatic wait_busy(input logic lvl, output int cnt);
    for (cnt = 0; cnt < 64 && busy !== lvl; cnt++) @(posedge sys_clk);
    if (cnt == 64) fail();
  endtask

  // offset binary from the core, msb turned over for two's complement
  function automatic logic [15:0] exp_code(input cfg_t c, input logic [15:0] raw);
    return (c.twos && c.in_range != RANGE_UNIPOLAR) ? {~raw[15], raw[14:0]} : raw;
  endfunction

  // main sequence
  initial begin
    seed      = 32'h5a35;
    n_errors  = 0;
    checked   = 0;
    reset_n   = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h00;
    pwdata    = WORD_ZERO;
    dev_reset = 1'b0;
    core_code = CODE_RESET;
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    foreach (OFS_LIST[i]) begin
      apb(1'b0, OFS_LIST[i], WORD_ZERO);
      chk("reset value", WORD_ZERO, rd);
    end
    apb(1'b0, 8'h20, WORD_ZERO);
    chk("unmapped error", 32'h0000_0001, 32'(err));
    $display("test registers done");
    // every coding mode; the first four hit the codes beside zero
    apb(1'b1, OFS_INT_MASK, 32'h0000_0001);
    for (int i = 0; i < 8; i++) begin
      cfg = cfg_t'($random(seed));
      cfg.spare = 1'b0;
      cfg.in_range = range_t'((i < 4) ? 0 : i / 2 - 1);
      cfg.twos = i[0];
      code = (i < 2) ? 16'h7fff : (i < 4) ? 16'h8000 : 16'($random(seed));
      ncfg = cfg_t'($random(seed));
      ncfg.spare = 1'b0;
      ncfg.in_range = range_t'(i % 3);
      apb(1'b1, OFS_CONFIG, 32'(cfg));
      core_code <= code;
      hm.convert();
      wait_busy(1'b1, n);
      chk("wake", 32'h0000_0001, 32'(core_wake));
      wait_busy(1'b0, n);
      chk("busy cycles", CONV_CYCLES, n);
      hm.xfer(ncfg, frame);
      chk("frame code", exp_code(cfg, code), frame[TX_W-1:CFG_W]);
      chk("frame cfg", 32'(cfg), frame[CFG_W-1:0]);
      chk("bus released", 32'h0000_0001, 32'(sdo_oe_n));
      chk("cfg pins", {ncfg.channel, ncfg.in_range, ncfg.gain_compression},
          {mux_channel, input_range, gain_compression});
      apb(1'b0, OFS_CONFIG, WORD_ZERO);
      chk("cfg loaded", 32'(ncfg), rd);
      apb(1'b0, OFS_RESULT, WORD_ZERO);
      chk("result reg", exp_code(cfg, code), rd);
      chk("irq set", 32'h0000_0001, 32'(irq));
      apb(1'b1, OFS_INT_STATUS, 32'h0000_0001);
      repeat (2) @(posedge sys_clk);
      chk("irq masked", WORD_ZERO, 32'(irq));
      apb(1'b0, OFS_INT_STATUS, WORD_ZERO);
      chk("events left", 32'h0000_0004, rd);
      apb(1'b1, OFS_INT_STATUS, 32'h0000_0004);
    end
    $display("test conversions done");
    // shift clock while the bus is disabled must change nothing
    hm.shift(2*CFG_W, ~ncfg, frame);
    apb(1'b0, OFS_CONFIG, WORD_ZERO);
    chk("gated cfg", 32'(ncfg), rd);
    apb(1'b0, OFS_INT_STATUS, WORD_ZERO);
    chk("gated events", WORD_ZERO, rd);
    $display("test gating done");
    // device reset pin in mid conversion
    hm.convert();
    wait_busy(1'b1, n);
    dev_reset <= 1'b1;
    repeat (10) @(posedge sys_clk);
    chk("abort busy", WORD_ZERO, 32'(busy));
    chk("abort bus", 32'h0000_0001, 32'(sdo_oe_n));
    dev_reset <= 1'b0;
    apb(1'b0, OFS_INT_STATUS, WORD_ZERO);
    chk("abort event", 32'h0000_0002, rd);
    $display("test abort done");
    end_of_test();
  end
endmodule // test_sar_adc_serial_control
